/* File: psg_cfg.svh */
/*
 * Constants of the peripheral memory SECDED guard: widths, depths,
 * check bit counts and reset values.
 * Assumes inclusion by bare name from the package and the guard module.
 */
`ifndef PSG_CFG_SVH
`define PSG_CFG_SVH

// ---------------------------------------------------------------------
// Geometry defaults
// ---------------------------------------------------------------------
`define PSG_DATA_W_DEF   32
`define PSG_DEPTH_DEF    256
`define PSG_COUNT_W_DEF  16

// ---------------------------------------------------------------------
// Hamming bits per word width (one overall parity bit is added)
// ---------------------------------------------------------------------
`define PSG_HAM_W_32     6
`define PSG_HAM_W_64     7
`define PSG_WIDE_LIMIT   32

// ---------------------------------------------------------------------
// Injection selections and reset values
// ---------------------------------------------------------------------
`define PSG_INJ_ONE      2'h1
`define PSG_INJ_TWO      2'h2
`define PSG_INJ_THREE    2'h3
`define PSG_MASK_ONE     3'h1
`define PSG_MASK_TWO     3'h3
`define PSG_MASK_THREE   3'h7
`define PSG_FLAG_RST     1'b0
`define PSG_INJ_SEL_RST  2'h1

`endif

/* File: psg_pkg.sv */
/*
 * Types of the peripheral memory SECDED guard.
 * Assumes psg_cfg.svh is on the include path.
 */
`include "psg_cfg.svh"

package psg_pkg;

    // -----------------------------------------------------------------
    // Outcome of decoding one read word
    // -----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PSG_RES_CLEAN,
        PSG_RES_SINGLE,
        PSG_RES_DOUBLE
    } psg_res_t;

endpackage

/* File: psg_guard.sv */
/*
 * SECDED guard around one peripheral memory instance: encoder, memory
 * array, decoder/corrector, status, count, interrupt and injection.
 * Assumes control inputs come from logic on I_CLOCK; DATA_W is 32 or 64.
 */
`timescale 1ns/1ps

`include "psg_cfg.svh"

module psg_guard
    import psg_pkg::*;
#(
    parameter int DATA_W  = `PSG_DATA_W_DEF,
    parameter int DEPTH   = `PSG_DEPTH_DEF,
    parameter int COUNT_W = `PSG_COUNT_W_DEF,
    parameter int ADDR_W  = $clog2(DEPTH)
)
(
    // Clock and reset
    input  wire logic               I_CLOCK,
    input  wire logic               I_RST,
    // Write port
    input  wire logic               I_WR_EN,
    input  wire logic [ADDR_W-1:0]  I_WR_ADDR,
    input  wire logic [DATA_W-1:0]  I_WR_DATA,
    // Read port
    input  wire logic               I_RD_EN,
    input  wire logic [ADDR_W-1:0]  I_RD_ADDR,
    input  wire logic               I_RD_BUS,
    output logic                    O_RD_VALID,
    output logic [DATA_W-1:0]       O_RD_DATA,
    output logic                    O_RD_ERR_RESP,
    output logic                    O_RD_CORRECTED,
    // Status and count
    input  wire logic               I_STAT_CLR,
    output logic                    O_STAT_CE,
    output logic                    O_STAT_UE,
    output logic                    O_STAT_LAST_UE,
    input  wire logic               I_COUNT_CLR,
    output logic [COUNT_W-1:0]      O_ERR_COUNT,
    // Interrupt
    input  wire logic               I_IRQ_EN_CE,
    input  wire logic               I_IRQ_EN_UE,
    output logic                    O_IRQ,
    // Error injection
    input  wire logic               I_INJ_ARM,
    input  wire logic [1:0]         I_INJ_SEL,
    output logic                    O_INJ_PENDING
);

    // -----------------------------------------------------------------
    // Code geometry
    // -----------------------------------------------------------------
    localparam int HAM_W  = (DATA_W > `PSG_WIDE_LIMIT) ?
                            `PSG_HAM_W_64 : `PSG_HAM_W_32;
    localparam int CHK_W  = HAM_W + 1;
    localparam int WORD_W = DATA_W + CHK_W;

    // Hamming bits over data placed at non power-of-two positions
    function automatic logic [HAM_W-1:0] ham_bits
    (
        input logic [DATA_W-1:0] d
    );
        logic [HAM_W-1:0] c;
        int               k;
        c = '0;
        k = 0;
        for (int pos = 1; pos <= DATA_W + HAM_W; pos++)
        begin
            if ((pos & (pos - 1)) != 0)
            begin
                for (int i = 0; i < HAM_W; i++)
                begin
                    if (pos[i])
                        c[i] = c[i] ^ d[k];
                end
                k++;
            end
        end
        return c;
    endfunction

    // Flip the data bit sitting at the syndrome position
    function automatic logic [DATA_W-1:0] fix_bit
    (
        input logic [DATA_W-1:0] d,
        input logic [HAM_W-1:0]  syn
    );
        logic [DATA_W-1:0] r;
        int                k;
        r = d;
        k = 0;
        for (int pos = 1; pos <= DATA_W + HAM_W; pos++)
        begin
            if ((pos & (pos - 1)) != 0)
            begin
                if (pos == int'(syn))
                    r[k] = ~r[k];
                k++;
            end
        end
        return r;
    endfunction

    // -----------------------------------------------------------------
    // Storage and state
    // -----------------------------------------------------------------
    logic [WORD_W-1:0]  mem [DEPTH];
    logic [WORD_W-1:0]  raw_reg;
    logic               rd_v_reg;
    logic               rd_bus_reg;
    logic               inj_arm_reg;
    logic [1:0]         inj_sel_reg;
    logic               ce_reg;
    logic               ue_reg;
    logic               last_ue_reg;
    logic [COUNT_W-1:0] count_reg;

    // -----------------------------------------------------------------
    // Encoder and injection
    // -----------------------------------------------------------------
    wire [HAM_W-1:0]  wr_ham = ham_bits(I_WR_DATA);
    wire              wr_par = (^I_WR_DATA) ^ (^wr_ham);
    wire [2:0]        inj_low =
        (inj_sel_reg == `PSG_INJ_THREE) ? `PSG_MASK_THREE :
        (inj_sel_reg == `PSG_INJ_TWO)   ? `PSG_MASK_TWO   :
                                          `PSG_MASK_ONE;
    wire [DATA_W-1:0] inj_mask =
        inj_arm_reg ? {{(DATA_W-3){1'b0}}, inj_low} : '0;
    wire [WORD_W-1:0] wr_word =
        {wr_par, wr_ham, I_WR_DATA ^ inj_mask};

    always_ff @(posedge I_CLOCK)
    begin
        if (I_WR_EN)
            mem[I_WR_ADDR] <= wr_word;
    end

    // Arm wins over consumption by a write in the same cycle
    wire inj_arm_next = I_INJ_ARM ? 1'b1 :
                        (I_WR_EN ? 1'b0 : inj_arm_reg);

    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            inj_arm_reg <= `PSG_FLAG_RST;
            inj_sel_reg <= `PSG_INJ_SEL_RST;
        end
        else
        begin
            inj_arm_reg <= inj_arm_next;
            if (I_INJ_ARM)
                inj_sel_reg <= I_INJ_SEL;
        end
    end

    // -----------------------------------------------------------------
    // Read stage: memory word
    // -----------------------------------------------------------------
    always_ff @(posedge I_CLOCK)
    begin
        if (I_RD_EN)
            raw_reg <= mem[I_RD_ADDR];
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            rd_v_reg   <= 1'b0;
            rd_bus_reg <= 1'b0;
        end
        else
        begin
            rd_v_reg   <= I_RD_EN;
            rd_bus_reg <= I_RD_BUS;
        end
    end

    // -----------------------------------------------------------------
    // Decoder and corrector
    // -----------------------------------------------------------------
    wire [DATA_W-1:0] rd_data = raw_reg[DATA_W-1:0];
    wire [HAM_W-1:0]  rd_ham  = raw_reg[DATA_W +: HAM_W];
    wire [HAM_W-1:0]  syn     = ham_bits(rd_data) ^ rd_ham;
    wire              par_bad = ^raw_reg;
    psg_res_t         res;
    assign res = par_bad       ? PSG_RES_SINGLE :
                 (syn != '0)   ? PSG_RES_DOUBLE : PSG_RES_CLEAN;
    wire ev_ce = rd_v_reg && (res == PSG_RES_SINGLE);
    wire ev_ue = rd_v_reg && (res == PSG_RES_DOUBLE);
    wire [DATA_W-1:0] out_data =
        (res == PSG_RES_SINGLE) ? fix_bit(rd_data, syn) : rd_data;

    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            O_RD_VALID     <= 1'b0;
            O_RD_DATA      <= '0;
            O_RD_ERR_RESP  <= 1'b0;
            O_RD_CORRECTED <= 1'b0;
        end
        else
        begin
            O_RD_VALID     <= rd_v_reg;
            if (rd_v_reg)
                O_RD_DATA  <= out_data;
            O_RD_ERR_RESP  <= ev_ue && rd_bus_reg;
            O_RD_CORRECTED <= ev_ce;
        end
    end

    // -----------------------------------------------------------------
    // Status, count, interrupt
    // -----------------------------------------------------------------
    wire              any_ev = ev_ce || ev_ue;
    wire [COUNT_W-1:0] count_inc =
        (&count_reg) ? count_reg : count_reg + 1'b1;
    wire [COUNT_W-1:0] count_next =
        I_COUNT_CLR ? (any_ev ? COUNT_W'(1) : '0) :
        (any_ev ? count_inc : count_reg);

    always_ff @(posedge I_CLOCK)
    begin
        if (I_RST)
        begin
            ce_reg      <= `PSG_FLAG_RST;
            ue_reg      <= `PSG_FLAG_RST;
            last_ue_reg <= `PSG_FLAG_RST;
            count_reg   <= '0;
        end
        else
        begin
            ce_reg    <= ev_ce || (ce_reg && !I_STAT_CLR);
            ue_reg    <= ev_ue || (ue_reg && !I_STAT_CLR);
            if (any_ev)
                last_ue_reg <= ev_ue;
            count_reg <= count_next;
        end
    end

    // -----------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------
    assign O_STAT_CE      = ce_reg;
    assign O_STAT_UE      = ue_reg;
    assign O_STAT_LAST_UE = last_ue_reg;
    assign O_ERR_COUNT    = count_reg;
    assign O_IRQ          = (ue_reg && I_IRQ_EN_UE) ||
                            (ce_reg && I_IRQ_EN_CE);
    assign O_INJ_PENDING  = inj_arm_reg;

endmodule // psg_guard

/* File: psg_guard_props.sv */
/*
 * Port checker for psg_guard, bound to every instance.
 * Assumes one I_CLOCK domain with synchronous I_RST.
 */
`timescale 1ns/1ps

module psg_guard_props
#(
    parameter int COUNT_W = 16
)
(
    // Inputs watched
    input wire logic               I_CLOCK,
    input wire logic               I_RST,
    input wire logic               I_RD_EN,
    input wire logic               I_RD_BUS,
    input wire logic               I_WR_EN,
    input wire logic               I_STAT_CLR,
    input wire logic               I_COUNT_CLR,
    input wire logic               I_IRQ_EN_CE,
    input wire logic               I_IRQ_EN_UE,
    input wire logic               I_INJ_ARM,
    // Outputs watched
    input wire logic               O_RD_VALID,
    input wire logic               O_RD_ERR_RESP,
    input wire logic               O_RD_CORRECTED,
    input wire logic               O_STAT_CE,
    input wire logic               O_STAT_UE,
    input wire logic               O_STAT_LAST_UE,
    input wire logic [COUNT_W-1:0] O_ERR_COUNT,
    input wire logic               O_IRQ,
    input wire logic               O_INJ_PENDING
);
    // ---------------------------------------------------------------
    // Port relations
    // ---------------------------------------------------------------
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);

    chk_read_lat: assert property (I_RD_EN |-> ##2 O_RD_VALID)
        else $error("read answer not two cycles after request");
    chk_no_stray: assert property (O_RD_VALID |-> $past(I_RD_EN, 2))
        else $error("read answer without request");
    chk_err_bus: assert property (O_RD_ERR_RESP |-> O_RD_VALID
        && $past(I_RD_BUS, 2) && O_STAT_UE && O_STAT_LAST_UE)
        else $error("error response without bus double error");
    chk_fix_okay: assert property (O_RD_CORRECTED |-> O_RD_VALID
        && !O_RD_ERR_RESP && O_STAT_CE && !O_STAT_LAST_UE)
        else $error("corrected answer flags wrong");
    chk_irq_gate: assert property (O_IRQ == (O_STAT_UE && I_IRQ_EN_UE
        || O_STAT_CE && I_IRQ_EN_CE))
        else $error("interrupt not gated by enables");
    chk_count_sat: assert property (&O_ERR_COUNT && !I_COUNT_CLR
        |=> &O_ERR_COUNT)
        else $error("error count wrapped");
    chk_count_hold: assert property (!I_COUNT_CLR ##1 !O_RD_VALID
        |-> $stable(O_ERR_COUNT))
        else $error("error count moved without event");
    chk_stat_clear: assert property (I_STAT_CLR ##1 !O_RD_VALID
        |-> !O_STAT_CE && !O_STAT_UE)
        else $error("status flags not cleared");
    chk_inj_arm: assert property (I_INJ_ARM |=> O_INJ_PENDING)
        else $error("injection not armed");
    chk_inj_use: assert property (O_INJ_PENDING && I_WR_EN
        && !I_INJ_ARM |=> !O_INJ_PENDING)
        else $error("injection not spent on write");

endmodule // psg_guard_props

bind psg_guard psg_guard_props #(.COUNT_W(COUNT_W)) u_psg_guard_props (
    .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_RD_EN(I_RD_EN),
    .I_RD_BUS(I_RD_BUS), .I_WR_EN(I_WR_EN), .I_STAT_CLR(I_STAT_CLR),
    .I_COUNT_CLR(I_COUNT_CLR), .I_IRQ_EN_CE(I_IRQ_EN_CE),
    .I_IRQ_EN_UE(I_IRQ_EN_UE), .I_INJ_ARM(I_INJ_ARM),
    .O_RD_VALID(O_RD_VALID), .O_RD_ERR_RESP(O_RD_ERR_RESP),
    .O_RD_CORRECTED(O_RD_CORRECTED), .O_STAT_CE(O_STAT_CE),
    .O_STAT_UE(O_STAT_UE), .O_STAT_LAST_UE(O_STAT_LAST_UE),
    .O_ERR_COUNT(O_ERR_COUNT), .O_IRQ(O_IRQ),
    .O_INJ_PENDING(O_INJ_PENDING));

/* File: psg_reader.sv */
/*
 * Reading master model: takes each read answer in its valid cycle.
 * Assumes answers arrive as one-cycle pulses on i_clk.
 */
`timescale 1ns/1ps

module psg_reader
(
    // Clock and answer
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_valid,
    input  wire logic       i_err,
    input  wire logic       i_fix,
    // Captured answer
    output logic [7:0]      o_seen,
    output logic            o_err,
    output logic            o_fix
);
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            o_seen <= 8'h00;
        else if (i_valid)
        begin
            o_seen <= o_seen + 8'h01;
            o_err  <= i_err;
            o_fix  <= i_fix;
        end
    end
endmodule // psg_reader

/* File: psg_guard_tb.sv */
/*
 * Testbench for psg_guard: 32-bit and 64-bit instances, read model.
 * Assumes psg_pkg and psg_cfg.svh compiled first.
 */
`timescale 1ns/1ps

module psg_guard_tb;
    localparam logic [31:0] D = 32'hA5C3_0F96;
    logic        clk = 1'h0, rst = 1'h1, we = 1'h0, re = 1'h0, bus = 1'h0;
    logic        sclr = 1'h0, cclr = 1'h0, ece = 1'h0, eue = 1'h0;
    logic        arm = 1'h0, v, er, co, ce, ue, lue, irq, pend, p_er, p_co;
    logic        arm2 = 1'h0, v2, er2, co2, ce2, ue2, lue2, irq2, pend2;
    logic        p_er2, p_co2;
    logic [1:0]  sel2 = 2'h0;
    logic [1:0]  sel = 2'h0, cnt, cnt2;
    logic [3:0]  wa = 4'h0, ra = 4'h0;
    logic [31:0] wd = 32'h0000_0000, rdat;
    logic [63:0] rd2;
    logic [7:0]  seen, seen2;
    int          n_errors = 0, checked = 0;

    always #5 clk = ~clk;

    psg_guard #(.DEPTH(16), .COUNT_W(2)) u_psg_guard (
        .I_CLOCK(clk), .I_RST(rst), .I_WR_EN(we), .I_WR_ADDR(wa),
        .I_WR_DATA(wd), .I_RD_EN(re), .I_RD_ADDR(ra), .I_RD_BUS(bus),
        .O_RD_VALID(v), .O_RD_DATA(rdat), .O_RD_ERR_RESP(er),
        .O_RD_CORRECTED(co), .I_STAT_CLR(sclr), .O_STAT_CE(ce),
        .O_STAT_UE(ue), .O_STAT_LAST_UE(lue), .I_COUNT_CLR(cclr),
        .O_ERR_COUNT(cnt), .I_IRQ_EN_CE(ece), .I_IRQ_EN_UE(eue),
        .O_IRQ(irq), .I_INJ_ARM(arm), .I_INJ_SEL(sel), .O_INJ_PENDING(pend));
    psg_guard #(.DATA_W(64), .DEPTH(16), .COUNT_W(2)) u_psg_guard_w64 (
        .I_CLOCK(clk), .I_RST(rst), .I_WR_EN(we), .I_WR_ADDR(wa),
        .I_WR_DATA({wd, ~wd}), .I_RD_EN(re), .I_RD_ADDR(ra), .I_RD_BUS(bus),
        .O_RD_VALID(v2), .O_RD_DATA(rd2), .O_RD_ERR_RESP(er2),
        .O_RD_CORRECTED(co2), .I_STAT_CLR(sclr), .O_STAT_CE(ce2),
        .O_STAT_UE(ue2), .O_STAT_LAST_UE(lue2), .I_COUNT_CLR(cclr),
        .O_ERR_COUNT(cnt2), .I_IRQ_EN_CE(ece), .I_IRQ_EN_UE(eue),
        .O_IRQ(irq2), .I_INJ_ARM(arm2), .I_INJ_SEL(sel2),
        .O_INJ_PENDING(pend2));
    psg_reader u_psg_reader (.i_clk(clk), .i_rst(rst), .i_valid(v),
        .i_err(er), .i_fix(co), .o_seen(seen), .o_err(p_er), .o_fix(p_co));
    psg_reader u_psg_reader_w64 (.i_clk(clk), .i_rst(rst), .i_valid(v2),
        .i_err(er2), .i_fix(co2), .o_seen(seen2), .o_err(p_er2),
        .o_fix(p_co2));

    // ---------------------------------------------------------------
    // Check, report and access tasks
    // ---------------------------------------------------------------
    task automatic chk(input string n, input logic [63:0] s, e);
        checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a);
        @(posedge clk);
        we <= 1'h1;
        wa <= a;
        wd <= D;
        @(posedge clk);
        we <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic b);
        logic [7:0] n0;
        n0 = seen;
        @(posedge clk);
        re <= 1'h1;
        ra <= a;
        bus <= b;
        @(posedge clk);
        re <= 1'h0;
        repeat (6)
        begin
            @(posedge clk);
            #1;
            if (seen !== n0)
                return;
        end
        n_errors++;
        $display("[FAIL] read_answer expected valid seen none");
        test_done;
    endtask
    task automatic inj(input logic [1:0] s);
        @(posedge clk);
        arm <= 1'h1;
        sel <= s;
        @(posedge clk);
        arm <= 1'h0;
        #1 chk("pend", pend, 1'h1);
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        wr(4'h1);
        rd(4'h1, 1'h1);
        chk("clean", {rdat, p_co}, {D, 1'h0});
        chk("wide", rd2, {D, ~D});
        for (int s = 0; s < 2; s++)
        begin
            inj(s[1:0]);
            wr(4'h2);
            rd(4'h2, 1'h1);
            chk("single", {rdat, p_co, p_er}, {D, 2'h2});
            chk("ce_lue", {ce, lue}, 2'h2);
            chk("count", cnt, s + 1);
        end
        chk("irq_off", irq, 1'h0);
        @(posedge clk) ece <= 1'h1;
        #1 chk("irq_ce", irq, 1'h1);
        @(posedge clk) sclr <= 1'h1;
        @(posedge clk) sclr <= 1'h0;
        #1 chk("ce_clr", {ce, irq}, 2'h0);
        inj(2'h2);
        wr(4'h3);
        rd(4'h3, 1'h1);
        chk("double", {rdat, p_er, p_co}, {D ^ 32'h0000_0003, 2'h2});
        chk("ue", {ue, lue, irq, cnt}, 5'h1B);
        @(posedge clk) eue <= 1'h1;
        #1 chk("irq_ue", irq, 1'h1);
        rd(4'h3, 1'h0);
        chk("stream", {rdat, p_er}, {D ^ 32'h0000_0003, 1'h0});
        chk("stream_irq", {irq, cnt}, 3'h7);
        inj(2'h3);
        wr(4'h4);
        #1 chk("pend_used", pend, 1'h0);
        rd(4'h4, 1'h1);
        chk("sat", cnt, 2'h3);
        @(posedge clk) cclr <= 1'h1;
        @(posedge clk) cclr <= 1'h0;
        rd(4'h4, 1'h0);
        chk("count_clr", cnt, 2'h1);
        chk("own", {cnt2, rd2}, {2'h0, D, ~D});
        @(posedge clk);
        arm2 <= 1'h1;
        sel2 <= 2'h1;
        @(posedge clk) arm2 <= 1'h0;
        #1 chk("pend_own", {pend2, pend}, 2'h2);
        wr(4'h5);
        rd(4'h5, 1'h1);
        chk("w64_fix", rd2, {D, ~D});
        chk("w64_flg", {p_co2, p_er2, lue2}, 3'h4);
        chk("w64_stat", {ce2, ue2, irq2, cnt2}, 5'h15);
        chk("own_32", {cnt, p_co, p_er}, 4'h4);
        chk("answers", {seen, seen2}, 16'h0808);
        test_done;
    end
endmodule // psg_guard_tb
